// file: hdl/dtc_pkg.sv
package dtc_pkg;

	// Special function register addresses
	localparam logic [7:0] DTC_ADDR_CTRL = 8'h88;
	localparam logic [7:0] DTC_ADDR_MODE = 8'h89;
	localparam logic [7:0] DTC_ADDR_TL0 = 8'h8a;
	localparam logic [7:0] DTC_ADDR_TL1 = 8'h8b;
	localparam logic [7:0] DTC_ADDR_TH0 = 8'h8c;
	localparam logic [7:0] DTC_ADDR_TH1 = 8'h8d;

	// Reset values
	localparam logic [7:0] DTC_CTRL_RST = 8'h00;
	localparam logic [7:0] DTC_MODE_RST = 8'h00;
	localparam logic [7:0] DTC_COUNT_RST = 8'h00;
	localparam logic [7:0] DTC_READ_NONE = 8'h00;

	// timer_control_flags fields
	localparam int DTC_TF1_BIT = 7;
	localparam int DTC_TR1_BIT = 6;
	localparam int DTC_TF0_BIT = 5;
	localparam int DTC_TR0_BIT = 4;
	localparam int DTC_IE1_BIT = 3;
	localparam int DTC_IT1_BIT = 2;
	localparam int DTC_IE0_BIT = 1;
	localparam int DTC_IT0_BIT = 0;

	// timer_mode_config fields
	localparam int DTC_GATE1_BIT = 7;
	localparam int DTC_FUNC1_BIT = 6;
	localparam int DTC_MODE1_LSB = 4;
	localparam int DTC_GATE0_BIT = 3;
	localparam int DTC_FUNC0_BIT = 2;
	localparam int DTC_MODE0_LSB = 0;

	// One machine cycle is six oscillator periods of clk_sys
	localparam int DTC_OSC_PER_MC = 6;
	localparam logic [2:0] DTC_MC_LAST = 3'(DTC_OSC_PER_MC - 1);

	typedef enum logic [1:0] {
		DTC_M13 = 2'b00,
		DTC_M16 = 2'b01,
		DTC_M8AR = 2'b10,
		DTC_MSPLIT = 2'b11
	} dtc_mode_t;

	typedef struct packed {
		logic [2:0] pre;
		logic [7:0] ctrl;
		logic [7:0] mode;
		logic [7:0] th0;
		logic [7:0] tl0;
		logic [7:0] th1;
		logic [7:0] tl1;
		logic [1:0] irq_prev;
		logic [7:0] rdata;
		logic ovf0;
		logic ovf1;
	} dtc_state_t;

	typedef struct packed {
		logic smp;
		logic pend;
	} dtc_smp_state_t;

endpackage

// file: hdl/dtc_pin_sampler.sv
`timescale 1ns/1ps
module dtc_pin_sampler import dtc_pkg::*; (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic mc_tick,
	input wire logic count_pin,
	output logic fall_seen
);

	dtc_smp_state_t s_q;
	dtc_smp_state_t s_d;

	// Pin is looked at only once per machine cycle; a fall found at one
	// tick is reported until the next tick, which is when it is counted.
	always_comb begin
		s_d = s_q;
		if (mc_tick) begin
			s_d.pend = s_q.smp & ~count_pin; // see R02
			s_d.smp = count_pin; // see R02
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign fall_seen = s_q.pend; // see R03

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	fall_detect_a: assert property (mc_tick && s_q.smp && !count_pin |=> fall_seen) // see R02
		else $error("falling count pin not detected");
	no_fall_a: assert property (mc_tick && !(s_q.smp && !count_pin) |=> !fall_seen) // see R02
		else $error("count pending without a falling sample");
	fall_cover_c: cover property (mc_tick && fall_seen);

endmodule

// file: hdl/dtc_timer_unit.sv
`timescale 1ns/1ps
// Behaviour
// R01: Timer function adds one each machine cycle of six oscillator periods.
// R02: Counter function samples pin per machine cycle, counts on high-then-low.
// R03: Detected fall is counted one machine cycle later; max rate osc/12.
// R04: Source holds each count pin level at least one machine cycle.
// R05: Mode bits 6 and 2 pick timer when 0, pin counting when 1.
// R06: Gate bit set: count only while run bit 1 and irq pin high.
// R07: Two-bit mode field per channel selects modes 0 to 3.
// R08: Mode 0 counts 13 bits: high byte above low five bits.
// R09: Count wrap from all ones to zero sets overflow flag.
// R10: Setting run bit keeps the count registers unchanged.
// R11: Mode 1 counts all 16 bits with no prescaler.
// R12: Mode 2 low byte counts; overflow reloads it from high byte.
// R13: Channel 1 in mode 3 holds its count as if stopped.
// R14: Channel 0 mode 3 low byte uses all of channel 0's controls.
// R15: Split high byte times cycles, run by channel 1 bit, sets its flag.
// R16: Channel 1 still counts, stops via own mode 3, gives overflow pulses.
// R17: Overflow flags set on overflow, cleared by vector ack or software.
// R18: Run bits are software written, turning channels on or off.
// R19: External irq flags set on edge or low, cleared by ack or software.
// R20: Trigger type bit set means falling edge, clear means low level.
// R21: Any reset clears the whole mode register.
// R22: Each channel emits a one-cycle overflow pulse for the serial port.
module dtc_timer_unit import dtc_pkg::*; (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic chan0_count_pin,
	input wire logic chan1_count_pin,
	input wire logic ext_irq0_pin,
	input wire logic ext_irq1_pin,
	input wire logic irq_ack_chan0,
	input wire logic irq_ack_chan1,
	input wire logic irq_ack_ext0,
	input wire logic irq_ack_ext1,
	output logic chan0_overflow_flag,
	output logic chan1_overflow_flag,
	output logic ext_irq0_detect_flag,
	output logic ext_irq1_detect_flag,
	output logic chan0_ovf_pulse,
	output logic chan1_ovf_pulse
);

	dtc_state_t s_q;
	dtc_state_t s_d;
	logic mc_tick;
	logic [1:0] fall_seen;
	logic [1:0] count_pins;
	dtc_mode_t mode0;
	dtc_mode_t mode1;
	logic en0;
	logic en1;
	logic ev0;
	logic ev1;
	logic evh;
	logic ovf0;
	logic ovf1;
	logic ovfh;
	logic set_tf0;
	logic set_tf1;
	logic [1:0] irq_set;

	// Step one count in modes 0, 1 and 2; returns {overflow, high, low}
	function automatic logic [16:0] dtc_step(input dtc_mode_t md,
			input logic [7:0] th, input logic [7:0] tl);
		logic [12:0] c13;
		logic [15:0] c16;
		logic [8:0] c8;
		c13 = {th, tl[4:0]} + 13'd1;
		c16 = {th, tl} + 16'd1;
		c8 = {1'b0, tl} + 9'd1;
		case (md)
			DTC_M13: begin
				// Top three low bits are left as they are
				dtc_step = {c13 == 13'd0, c13[12:5], tl[7:5], c13[4:0]}; // see R08
			end
			DTC_M16: begin
				dtc_step = {c16 == 16'd0, c16}; // see R11
			end
			DTC_M8AR: begin
				if (c8[8]) begin
					dtc_step = {1'b1, th, th}; // see R12
				end else begin
					dtc_step = {1'b0, th, c8[7:0]}; // see R12
				end
			end
			default: begin
				dtc_step = {1'b0, th, tl};
			end
		endcase
	endfunction

	// Plain 8-bit step for the two halves of split mode
	function automatic logic [8:0] dtc_inc8(input logic [7:0] v);
		dtc_inc8 = {1'b0, v} + 9'd1;
	endfunction

	assign count_pins = {chan1_count_pin, chan0_count_pin};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_smp
			dtc_pin_sampler u_smp (
				.clk_sys(clk_sys),
				.resetn(resetn),
				.mc_tick(mc_tick),
				.count_pin(count_pins[gi]),
				.fall_seen(fall_seen[gi])
			);
		end
	endgenerate

	assign mc_tick = (s_q.pre == DTC_MC_LAST); // see R01
	assign mode0 = dtc_mode_t'(s_q.mode[DTC_MODE0_LSB +: 2]); // see R07
	assign mode1 = dtc_mode_t'(s_q.mode[DTC_MODE1_LSB +: 2]); // see R07

	always_comb begin
		s_d = s_q;
		ovf0 = 1'b0;
		ovf1 = 1'b0;
		ovfh = 1'b0;
		s_d.pre = mc_tick ? 3'd0 : s_q.pre + 3'd1; // see R01

		en0 = s_q.ctrl[DTC_TR0_BIT]
			& (~s_q.mode[DTC_GATE0_BIT] | ext_irq0_pin); // see R06
		// Channel 1 in its own mode 3 acts as if its run bit were clear
		en1 = s_q.ctrl[DTC_TR1_BIT]
			& (~s_q.mode[DTC_GATE1_BIT] | ext_irq1_pin)
			& (mode1 != DTC_MSPLIT); // see R13
		ev0 = mc_tick & en0
			& (s_q.mode[DTC_FUNC0_BIT] ? fall_seen[0] : 1'b1); // see R05
		ev1 = mc_tick & en1
			& (s_q.mode[DTC_FUNC1_BIT] ? fall_seen[1] : 1'b1); // see R05
		evh = mc_tick & s_q.ctrl[DTC_TR1_BIT]; // see R15

		if (mode0 == DTC_MSPLIT) begin
			if (ev0) begin
				{ovf0, s_d.tl0} = dtc_inc8(s_q.tl0); // see R14
			end
			if (evh) begin
				{ovfh, s_d.th0} = dtc_inc8(s_q.th0); // see R15
			end
		end else if (ev0) begin
			{ovf0, s_d.th0, s_d.tl0} = dtc_step(mode0, s_q.th0, s_q.tl0);
		end
		if (ev1) begin
			{ovf1, s_d.th1, s_d.tl1} = dtc_step(mode1, s_q.th1, s_q.tl1); // see R16
		end

		// Split high byte takes over channel 1's flag
		set_tf0 = ovf0; // see R09
		set_tf1 = (mode0 == DTC_MSPLIT) ? ovfh : ovf1; // see R15
		s_d.ovf0 = ovf0; // see R22
		s_d.ovf1 = ovf1; // see R16

		// A software write to a count byte wins over a count in that cycle;
		// writing the control register leaves counts alone.
		if (sfr_wr) begin
			if (sfr_addr == DTC_ADDR_CTRL) begin
				s_d.ctrl = sfr_wdata; // see R18, see R10
			end else if (sfr_addr == DTC_ADDR_MODE) begin
				s_d.mode = sfr_wdata; // see R07
			end else if (sfr_addr == DTC_ADDR_TL0) begin
				s_d.tl0 = sfr_wdata;
			end else if (sfr_addr == DTC_ADDR_TL1) begin
				s_d.tl1 = sfr_wdata;
			end else if (sfr_addr == DTC_ADDR_TH0) begin
				s_d.th0 = sfr_wdata;
			end else if (sfr_addr == DTC_ADDR_TH1) begin
				s_d.th1 = sfr_wdata;
			end
		end

		// External interrupt detection: falling edge or low level
		irq_set[0] = s_q.ctrl[DTC_IT0_BIT]
			? (s_q.irq_prev[0] & ~ext_irq0_pin) : ~ext_irq0_pin; // see R20
		irq_set[1] = s_q.ctrl[DTC_IT1_BIT]
			? (s_q.irq_prev[1] & ~ext_irq1_pin) : ~ext_irq1_pin; // see R20
		s_d.irq_prev = {ext_irq1_pin, ext_irq0_pin};

		// Hardware clears first, then hardware sets, so a new event survives
		if (irq_ack_chan0) begin
			s_d.ctrl[DTC_TF0_BIT] = 1'b0; // see R17
		end
		if (irq_ack_chan1) begin
			s_d.ctrl[DTC_TF1_BIT] = 1'b0; // see R17
		end
		if (irq_ack_ext0) begin
			s_d.ctrl[DTC_IE0_BIT] = 1'b0; // see R19
		end
		if (irq_ack_ext1) begin
			s_d.ctrl[DTC_IE1_BIT] = 1'b0; // see R19
		end
		if (set_tf0) begin
			s_d.ctrl[DTC_TF0_BIT] = 1'b1; // see R17
		end
		if (set_tf1) begin
			s_d.ctrl[DTC_TF1_BIT] = 1'b1; // see R17
		end
		if (irq_set[0]) begin
			s_d.ctrl[DTC_IE0_BIT] = 1'b1; // see R19
		end
		if (irq_set[1]) begin
			s_d.ctrl[DTC_IE1_BIT] = 1'b1; // see R19
		end

		if (sfr_rd) begin
			if (sfr_addr == DTC_ADDR_CTRL) begin
				s_d.rdata = s_q.ctrl;
			end else if (sfr_addr == DTC_ADDR_MODE) begin
				s_d.rdata = s_q.mode;
			end else if (sfr_addr == DTC_ADDR_TL0) begin
				s_d.rdata = s_q.tl0;
			end else if (sfr_addr == DTC_ADDR_TL1) begin
				s_d.rdata = s_q.tl1;
			end else if (sfr_addr == DTC_ADDR_TH0) begin
				s_d.rdata = s_q.th0;
			end else if (sfr_addr == DTC_ADDR_TH1) begin
				s_d.rdata = s_q.th1;
			end else begin
				s_d.rdata = DTC_READ_NONE;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_q.pre <= 3'd0;
			s_q.ctrl <= DTC_CTRL_RST;
			s_q.mode <= DTC_MODE_RST; // see R21
			s_q.th0 <= DTC_COUNT_RST;
			s_q.tl0 <= DTC_COUNT_RST;
			s_q.th1 <= DTC_COUNT_RST;
			s_q.tl1 <= DTC_COUNT_RST;
			s_q.irq_prev <= 2'b11;
			s_q.rdata <= DTC_READ_NONE;
			s_q.ovf0 <= 1'b0;
			s_q.ovf1 <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sfr_rdata = s_q.rdata;
	assign chan0_overflow_flag = s_q.ctrl[DTC_TF0_BIT];
	assign chan1_overflow_flag = s_q.ctrl[DTC_TF1_BIT];
	assign ext_irq0_detect_flag = s_q.ctrl[DTC_IE0_BIT];
	assign ext_irq1_detect_flag = s_q.ctrl[DTC_IE1_BIT];
	assign chan0_ovf_pulse = s_q.ovf0;
	assign chan1_ovf_pulse = s_q.ovf1;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	mc_period_a: assert property (mc_tick |=> !mc_tick [*5] ##1 mc_tick) // see R01
		else $error("machine cycle is not six clocks");
	timer_step_a: assert property (mc_tick && en1 && !s_q.mode[DTC_FUNC1_BIT]
			&& mode1 == DTC_M16 && !sfr_wr
			|=> {s_q.th1, s_q.tl1} == $past({s_q.th1, s_q.tl1}) + 16'd1) // see R11
		else $error("timer did not step by one");
	edge_count_a: assert property (mc_tick && en0 && s_q.mode[DTC_FUNC0_BIT]
			&& mode0 == DTC_M16 && fall_seen[0] && !sfr_wr
			|=> {s_q.th0, s_q.tl0} == $past({s_q.th0, s_q.tl0}) + 16'd1) // see R03
		else $error("detected fall not counted");
	gate_hold_a: assert property (s_q.mode[DTC_GATE0_BIT] && !ext_irq0_pin
			&& mode0 != DTC_MSPLIT && !sfr_wr
			|=> $stable({s_q.th0, s_q.tl0})) // see R06
		else $error("gated channel counted with pin low");
	ch1_hold_a: assert property (mode1 == DTC_MSPLIT && !sfr_wr
			|=> $stable({s_q.th1, s_q.tl1}) && !chan1_ovf_pulse) // see R13
		else $error("channel 1 in mode 3 moved");
	ovf_flag_a: assert property (chan0_ovf_pulse |-> chan0_overflow_flag) // see R09
		else $error("overflow pulse without flag");
	reload_a: assert property (mode1 == DTC_M8AR && ev1 && s_q.tl1 == 8'hff
			&& !sfr_wr |=> s_q.tl1 == s_q.th1 && chan1_ovf_pulse) // see R12
		else $error("auto reload missed");
	m13_wrap_a: assert property (mode0 == DTC_M13 && ev0 && s_q.th0 == 8'hff
			&& s_q.tl0[4:0] == 5'h1f && !sfr_wr
			|=> s_q.th0 == 8'h00 && s_q.tl0[4:0] == 5'h00
			&& chan0_overflow_flag) // see R08
		else $error("13-bit wrap wrong");
	split_tf1_a: assert property (mode0 == DTC_MSPLIT && evh && s_q.th0 == 8'hff
			&& !sfr_wr |=> chan1_overflow_flag) // see R15
		else $error("split high byte did not set flag");
	set_wins_a: assert property (set_tf0 && irq_ack_chan0
			|=> chan0_overflow_flag) // see R17
		else $error("overflow lost to clear");
	irq_level_a: assert property (!s_q.ctrl[DTC_IT1_BIT] && !ext_irq1_pin
			|=> ext_irq1_detect_flag) // see R20
		else $error("low level not detected");
	// Own disable so the reset cycle itself is watched
	mode_reset_a: assert property (@(posedge clk_sys) disable iff (1'b0)
			!resetn |=> s_q.mode == DTC_MODE_RST) // see R21
		else $error("mode register not cleared by reset");

	split_run_c: cover property (mode0 == DTC_MSPLIT && ovfh);
	reload_c: cover property (mode1 == DTC_M8AR && ovf1);
	edge_c: cover property (s_q.ctrl[DTC_IT0_BIT] && irq_set[0]);

endmodule

// file: verification/dtc_pin_model.sv
`timescale 1ns/1ps
module dtc_pin_model (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic go,
	input wire logic sel,
	input wire logic [3:0] nfall,
	input wire logic [1:0] gate_lvl,
	output logic chan0_count_pin,
	output logic chan1_count_pin,
	output logic ext_irq0_pin,
	output logic ext_irq1_pin,
	output logic busy
);
	logic [3:0] left_q;
	logic [2:0] ph_q;
	logic lvl_q;
	// Idle count pins rest high, like a pulled-up port pin
	assign chan0_count_pin = sel ? 1'b1 : lvl_q;
	assign chan1_count_pin = sel ? lvl_q : 1'b1;
	assign ext_irq0_pin = gate_lvl[0];
	assign ext_irq1_pin = gate_lvl[1];
	assign busy = (left_q != 4'h0);
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			left_q <= 4'h0;
			ph_q <= 3'h0;
			lvl_q <= 1'b1;
		end else if (go) begin
			left_q <= nfall;
			ph_q <= 3'h0;
			lvl_q <= 1'b1;
		end else if (busy) begin
			// Six clocks per level so every level meets one sample
			ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
			if (ph_q == 3'h5) begin
				lvl_q <= ~lvl_q;
				if (!lvl_q)
					left_q <= left_q - 4'h1;
			end
		end
	end
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
module tb import dtc_pkg::*;;
	logic clk_sys, resetn, sfr_wr, sfr_rd, go, sel;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
	logic [3:0] ack, nfall;
	logic [1:0] gate_lvl;
	logic c0_pin, c1_pin, irq0_pin, irq1_pin, busy;
	logic f0, f1, e0, e1, p0, p1;
	logic f0_s = 1'b0;
	logic f1_s = 1'b0;
	int error_cnt = 0;
	int checks = 0;
	int p0_n = 0;
	int p1_n = 0;

	dtc_timer_unit dut (.clk_sys(clk_sys), .resetn(resetn),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.chan0_count_pin(c0_pin), .chan1_count_pin(c1_pin),
		.ext_irq0_pin(irq0_pin), .ext_irq1_pin(irq1_pin),
		.irq_ack_chan0(ack[0]), .irq_ack_chan1(ack[1]),
		.irq_ack_ext0(ack[2]), .irq_ack_ext1(ack[3]),
		.chan0_overflow_flag(f0), .chan1_overflow_flag(f1),
		.ext_irq0_detect_flag(e0), .ext_irq1_detect_flag(e1),
		.chan0_ovf_pulse(p0), .chan1_ovf_pulse(p1));

	dtc_pin_model pins (.clk_sys(clk_sys), .resetn(resetn), .go(go),
		.sel(sel), .nfall(nfall), .gate_lvl(gate_lvl),
		.chan0_count_pin(c0_pin), .chan1_count_pin(c1_pin),
		.ext_irq0_pin(irq0_pin), .ext_irq1_pin(irq1_pin), .busy(busy));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		if (p0 === 1'b1)
			p0_n++;
		if (p1 === 1'b1)
			p1_n++;
		// Sticky copies: the stop write clears the flags again
		if (f0 === 1'b1)
			f0_s <= 1'b1;
		if (f1 === 1'b1)
			f1_s <= 1'b1;
	end

	task give_verdict;
		$display("checks=%0d errors=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task check(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		sfr_wr <= 1'b1;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge clk_sys);
		sfr_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk_sys);
		sfr_rd <= 1'b1;
		sfr_addr <= a;
		@(posedge clk_sys);
		sfr_rd <= 1'b0;
		#1;
		check(sfr_rdata & m, e);
	endtask

	// Run bits on for exactly 6*n clocks, so n ticks land whatever the phase
	task run(input logic [7:0] c, input int n);
		f0_s <= 1'b0;
		f1_s <= 1'b0;
		wr(DTC_ADDR_CTRL, c);
		repeat (6 * n - 2) @(posedge clk_sys);
		wr(DTC_ADDR_CTRL, 8'h00);
		@(posedge clk_sys);
		#1;
	endtask

	task pulse_ack(input int i);
		@(posedge clk_sys);
		ack[i] <= 1'b1;
		@(posedge clk_sys);
		ack[i] <= 1'b0;
		@(posedge clk_sys);
		#1;
	endtask

	task falls(input logic s, input logic [3:0] n);
		@(posedge clk_sys);
		sel <= s;
		nfall <= n;
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		repeat (400) begin
			@(posedge clk_sys);
			if (busy === 1'b0)
				break;
		end
		repeat (14) @(posedge clk_sys);
	endtask

	task t_reset;
		rd(DTC_ADDR_CTRL, 8'hff, 8'h00);
		rd(DTC_ADDR_MODE, 8'hff, 8'h00);
		wr(8'h90, 8'ha5);
		rd(DTC_ADDR_MODE, 8'hff, 8'h00);
		rd(8'h90, 8'hff, 8'h00);
		wr(DTC_ADDR_MODE, 8'ha5);
		rd(DTC_ADDR_MODE, 8'hff, 8'ha5);
		@(posedge clk_sys);
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(DTC_ADDR_MODE, 8'hff, 8'h00);
		$display("t_reset done");
	endtask

	task t_mode1;
		wr(DTC_ADDR_TL0, 8'hfe);
		wr(DTC_ADDR_TH0, 8'hff);
		wr(DTC_ADDR_MODE, 8'h01);
		rd(DTC_ADDR_MODE, 8'hff, 8'h01);
		run(8'h10, 2);
		check({7'h0, f0_s}, 8'h01);
		check(8'(p0_n), 8'h01);
		rd(DTC_ADDR_TL0, 8'hff, 8'h00);
		rd(DTC_ADDR_TH0, 8'hff, 8'h00);
		wr(DTC_ADDR_CTRL, 8'h20);
		#1;
		check({7'h0, f0}, 8'h01);
		pulse_ack(0);
		check({7'h0, f0}, 8'h00);
		$display("t_mode1 done");
	endtask

	task t_mode0;
		wr(DTC_ADDR_TL1, 8'h1f);
		wr(DTC_ADDR_TH1, 8'hff);
		wr(DTC_ADDR_MODE, 8'h00);
		run(8'h40, 1);
		check({7'h0, f1_s}, 8'h01);
		check(8'(p1_n), 8'h01);
		rd(DTC_ADDR_TL1, 8'h1f, 8'h00);
		rd(DTC_ADDR_TH1, 8'hff, 8'h00);
		wr(DTC_ADDR_CTRL, 8'h80);
		pulse_ack(1);
		check({7'h0, f1}, 8'h00);
		$display("t_mode0 done");
	endtask

	task t_mode2;
		wr(DTC_ADDR_TH0, 8'h80);
		wr(DTC_ADDR_TL0, 8'hff);
		wr(DTC_ADDR_MODE, 8'h02);
		run(8'h10, 1);
		check({7'h0, f0_s}, 8'h01);
		rd(DTC_ADDR_TL0, 8'hff, 8'h80);
		rd(DTC_ADDR_TH0, 8'hff, 8'h80);
		check(8'(p0_n), 8'h02);
		wr(DTC_ADDR_CTRL, 8'h20);
		#1;
		check({7'h0, f0}, 8'h01);
		wr(DTC_ADDR_CTRL, 8'h00);
		#1;
		check({7'h0, f0}, 8'h00);
		$display("t_mode2 done");
	endtask

	task t_split;
		wr(DTC_ADDR_TL0, 8'h55);
		wr(DTC_ADDR_TH0, 8'hff);
		wr(DTC_ADDR_MODE, 8'h33);
		run(8'h40, 1);
		check({7'h0, f1_s}, 8'h01);
		check({7'h0, f0}, 8'h00);
		check(8'(p1_n), 8'h01);
		rd(DTC_ADDR_TH0, 8'hff, 8'h00);
		rd(DTC_ADDR_TL0, 8'hff, 8'h55);
		rd(DTC_ADDR_TL1, 8'hff, 8'h00);
		rd(DTC_ADDR_TH1, 8'hff, 8'h00);
		pulse_ack(1);
		$display("t_split done");
	endtask

	task t_count;
		wr(DTC_ADDR_TL1, 8'h00);
		wr(DTC_ADDR_MODE, 8'h50);
		wr(DTC_ADDR_CTRL, 8'h40);
		falls(1'b1, 4'h3);
		rd(DTC_ADDR_TL1, 8'hff, 8'h03);
		wr(DTC_ADDR_MODE, 8'hd0);
		gate_lvl <= 2'b01;
		falls(1'b1, 4'h2);
		rd(DTC_ADDR_TL1, 8'hff, 8'h03);
		gate_lvl <= 2'b11;
		falls(1'b1, 4'h2);
		rd(DTC_ADDR_TL1, 8'hff, 8'h05);
		pulse_ack(3);
		check({7'h0, e1}, 8'h00);
		wr(DTC_ADDR_TL0, 8'h00);
		wr(DTC_ADDR_MODE, 8'h55);
		wr(DTC_ADDR_CTRL, 8'h10);
		falls(1'b0, 4'h2);
		rd(DTC_ADDR_TL0, 8'hff, 8'h02);
		rd(DTC_ADDR_TL1, 8'hff, 8'h05);
		wr(DTC_ADDR_CTRL, 8'h00);
		$display("t_count done");
	endtask

	task t_irq;
		wr(DTC_ADDR_CTRL, 8'h01);
		gate_lvl <= 2'b10;
		repeat (2) @(posedge clk_sys);
		#1;
		check({7'h0, e0}, 8'h01);
		pulse_ack(2);
		check({7'h0, e0}, 8'h00);
		wr(DTC_ADDR_CTRL, 8'h00);
		repeat (2) @(posedge clk_sys);
		#1;
		check({7'h0, e0}, 8'h01);
		pulse_ack(2);
		check({7'h0, e0}, 8'h01);
		@(posedge clk_sys);
		gate_lvl <= 2'b11;
		pulse_ack(2);
		check({7'h0, e0}, 8'h00);
		$display("t_irq done");
	endtask

	initial begin
		resetn = 1'b0;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		ack = 4'h0;
		go = 1'b0;
		sel = 1'b0;
		nfall = 4'h0;
		gate_lvl = 2'b11;
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		t_reset;
		t_mode1;
		t_mode0;
		t_mode2;
		t_split;
		t_count;
		t_irq;
		give_verdict;
	end

	// Whole run needs a few hundred clocks; this only cuts a hang
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		give_verdict;
	end
endmodule
